// file: design/pmcg_once.sv
// Purpose: Bank of write-once lock latches
// Assumes: Synchronous active-high reset clears every latch
// Notes:   A latch sets on the first write strobe and holds until reset
`timescale 1ns/10ps
module pmcg_once #(
  parameter int N = 1
) (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  pmcg_once_if.bank  once
);
  logic [N-1:0] lock_q;
  logic [N-1:0] lock_d;

  // One latch per write-once bit
  for (genvar i = 0; i < N; i++) begin : g_lock
    always_comb begin
      lock_d[i] = lock_q[i] | once.wr_hit[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q <= '0;
    end else if (ce) begin
      lock_q <= lock_d;
    end
  end

  assign once.locked = lock_q;
endmodule // pmcg_once

// file: design/pmcg_once_if.sv
// Purpose: Carries write strobes and lock state of the write-once latches
// Assumes: One clock domain
// Notes:   Bank drives locked, control logic drives wr_hit
`timescale 1ns/10ps
interface pmcg_once_if #(parameter int N = 1);
  logic [N-1:0] wr_hit;
  logic [N-1:0] locked;
  modport ctrl (output wr_hit, input locked);
  modport bank (input wr_hit, output locked);
endinterface : pmcg_once_if

// file: design/pmcg_pkg.sv
// Purpose: Shared constants for the power mode and clock gating register bank
// Assumes: 32-bit classic Wishbone slave, each register in the low byte of one word
// Notes:   Functional notes follow
package pmcg_pkg;
  // Register byte addresses on the bus
  localparam logic [3:0] PMCG_ADR_PM_TWO   = 4'h0;
  localparam logic [3:0] PMCG_ADR_PM_THREE = 4'h4;
  localparam logic [3:0] PMCG_ADR_GATE_ONE = 4'h8;
  // Second power register fields
  localparam int PM2_LPREG_BIT = 7;
  localparam int PM2_FLAG_BIT  = 3;
  localparam int PM2_ACK_BIT   = 2;
  localparam int PM2_EN_BIT    = 1;
  localparam int PM2_SEL_BIT   = 0;
  // Third power register fields
  localparam int PM3_FLAG_BIT = 7;
  localparam int PM3_ACK_BIT  = 6;
  localparam int PM3_DET_BIT  = 5;
  localparam int PM3_WRN_BIT  = 4;
  localparam int PM3_IE_BIT   = 3;
  // Values after reset
  localparam logic [7:0] GATE_ONE_RESET = 8'hFF;
  localparam logic       CTRL_RESET     = 1'b0;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;
  // Number of write-once bits
  localparam int ONCE_BITS = 1;
endpackage : pmcg_pkg

// file: design/pmcg_regs.sv
// Purpose: Power mode control, low-voltage warning and peripheral clock gate registers
// Assumes: Classic Wishbone slave, ack one cycle after strobe; software is sole party
// Notes:   Power-on reset also clears the threshold selects; other resets keep them
`timescale 1ns/10ps
module pmcg_regs (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  input  wire logic        RESET_IS_POR,
  input  wire logic        DEEP_STOP_WAKE,
  input  wire logic        WARN_BELOW_ASYNC,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [3:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  output logic             PPD_ENABLE,
  output logic             DEEP_STOP_SELECT,
  output logic             LOW_POWER_REG_EN,
  output logic             DETECT_THRESH_SEL,
  output logic             WARN_THRESH_SEL,
  output logic             WARN_IRQ,
  output logic [7:0]       PERIPH_CLK_EN
);
  logic        warn_lvl;
  logic        ack_q,  ack_d;
  logic [31:0] rd_q,   rd_d;
  logic        pdn_flag_q, pdn_flag_d;
  logic        pdn_en_q, pdn_en_d;
  logic        mode_sel_q, mode_sel_d;
  logic        lp_reg_q, lp_reg_d;
  logic        warn_flag_q, warn_flag_d;
  logic        det_sel_q, det_sel_d;
  logic        wrn_sel_q, wrn_sel_d;
  logic        ie_q,   ie_d;
  logic        irq_q,  irq_d;
  logic [7:0]  gate_q, gate_d;
  logic        req;
  logic        wr;
  logic        wr_pm2;
  logic        wr_pm3;
  logic        wr_gate;
  logic [7:0]  wd;
  logic        pdn_en_new;
  logic        mode_sel_new;

  pmcg_once_if #(.N(pmcg_pkg::ONCE_BITS)) once_if ();

  // Comparator is analog, so it is brought in through the filtered synchroniser
  pmcg_sync u_warn_sync (
    .clk  (CLOCK),
    .rst  (RESET),
    .ce   (CLK_EN),
    .din  (WARN_BELOW_ASYNC),
    .dout (warn_lvl)
  );

  pmcg_once #(.N(pmcg_pkg::ONCE_BITS)) u_once (
    .clk  (CLOCK),
    .rst  (RESET),
    .ce   (CLK_EN),
    .once (once_if.bank)
  );

  // Bus decode; the write lands on the edge where ack rises
  always_comb begin
    req     = CYC_I & STB_I & ~ack_q;
    wr      = req & WE_I & SEL_I[0];
    wd      = DAT_I[7:0];
    wr_pm2  = wr & (ADR_I == pmcg_pkg::PMCG_ADR_PM_TWO);
    wr_pm3  = wr & (ADR_I == pmcg_pkg::PMCG_ADR_PM_THREE);
    wr_gate = wr & (ADR_I == pmcg_pkg::PMCG_ADR_GATE_ONE);
    once_if.wr_hit = wr_pm2;
  end

  // Second power register: flag, write-once enable and mode select
  always_comb begin
    pdn_flag_d = pdn_flag_q;
    pdn_en_d   = pdn_en_q;
    mode_sel_d = mode_sel_q;
    lp_reg_d   = lp_reg_q;
    pdn_en_new = once_if.locked[0] ? pdn_en_q : wd[pmcg_pkg::PM2_EN_BIT];
    // Select needs the enable and a clear regulator bit
    mode_sel_new = wd[pmcg_pkg::PM2_SEL_BIT] & pdn_en_new & ~lp_reg_q;
    if (wr_pm2) begin
      pdn_en_d   = pdn_en_new;
      mode_sel_d = mode_sel_new;
      // A simultaneous select wins over the regulator bit
      lp_reg_d   = wd[pmcg_pkg::PM2_LPREG_BIT] & ~mode_sel_new;
      if (wd[pmcg_pkg::PM2_ACK_BIT]) begin
        pdn_flag_d = 1'b0;
      end
    end
    // Wakeup from deep stop sets the flag; it wins over an acknowledge
    if (DEEP_STOP_WAKE) begin
      pdn_flag_d = 1'b1;
      pdn_en_d   = 1'b1;
      mode_sel_d = 1'b1;
      lp_reg_d   = 1'b0;
    end
  end

  // Mode state; the wake path bypasses the write-once lock on purpose
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pdn_flag_q <= pmcg_pkg::CTRL_RESET;
      pdn_en_q   <= pmcg_pkg::CTRL_RESET;
      mode_sel_q <= pmcg_pkg::CTRL_RESET;
      lp_reg_q   <= pmcg_pkg::CTRL_RESET;
    end else if (CLK_EN) begin
      pdn_flag_q <= pdn_flag_d;
      pdn_en_q   <= pdn_en_d;
      mode_sel_q <= mode_sel_d;
      lp_reg_q   <= lp_reg_d;
    end
  end

  // Third power register: warning flag, thresholds, interrupt enable
  always_comb begin
    warn_flag_d = warn_flag_q;
    det_sel_d   = det_sel_q;
    wrn_sel_d   = wrn_sel_q;
    ie_d        = ie_q;
    if (wr_pm3) begin
      det_sel_d = wd[pmcg_pkg::PM3_DET_BIT];
      wrn_sel_d = wd[pmcg_pkg::PM3_WRN_BIT];
      ie_d      = wd[pmcg_pkg::PM3_IE_BIT];
      if (wd[pmcg_pkg::PM3_ACK_BIT]) begin
        warn_flag_d = 1'b0;
      end
    end
    // Level-sensitive set covers a supply already low when reset ends
    if (warn_lvl) begin
      warn_flag_d = 1'b1;
    end
    irq_d = warn_flag_d & ie_d;
  end

  // Threshold selects survive all but power-on reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      warn_flag_q <= pmcg_pkg::CTRL_RESET;
      ie_q        <= pmcg_pkg::CTRL_RESET;
      irq_q       <= pmcg_pkg::CTRL_RESET;
      if (RESET_IS_POR) begin
        det_sel_q <= pmcg_pkg::CTRL_RESET;
        wrn_sel_q <= pmcg_pkg::CTRL_RESET;
      end
    end else if (CLK_EN) begin
      warn_flag_q <= warn_flag_d;
      det_sel_q   <= det_sel_d;
      wrn_sel_q   <= wrn_sel_d;
      ie_q        <= ie_d;
      irq_q       <= irq_d;
    end
  end

  // Clock gate register; software must quiesce a peripheral first
  always_comb begin
    gate_d = wr_gate ? wd : gate_q;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gate_q <= pmcg_pkg::GATE_ONE_RESET;
    end else if (CLK_EN) begin
      gate_q <= gate_d;
    end
  end

  // Read mux and ack; unmapped addresses ack with zero data
  always_comb begin
    ack_d = req;
    rd_d  = '0;
    if (req && !WE_I) begin
      unique case (ADR_I)
        pmcg_pkg::PMCG_ADR_PM_TWO: begin
          rd_d[pmcg_pkg::PM2_LPREG_BIT] = lp_reg_q;
          rd_d[pmcg_pkg::PM2_FLAG_BIT]  = pdn_flag_q;
          rd_d[pmcg_pkg::PM2_EN_BIT]    = pdn_en_q;
          rd_d[pmcg_pkg::PM2_SEL_BIT]   = mode_sel_q;
        end
        pmcg_pkg::PMCG_ADR_PM_THREE: begin
          rd_d[pmcg_pkg::PM3_FLAG_BIT] = warn_flag_q;
          rd_d[pmcg_pkg::PM3_DET_BIT]  = det_sel_q;
          rd_d[pmcg_pkg::PM3_WRN_BIT]  = wrn_sel_q;
          rd_d[pmcg_pkg::PM3_IE_BIT]   = ie_q;
        end
        pmcg_pkg::PMCG_ADR_GATE_ONE: begin
          rd_d[7:0] = gate_q;
        end
        default: begin
          rd_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ack_q <= 1'b0;
      rd_q  <= '0;
    end else if (CLK_EN) begin
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end

  assign DAT_O             = rd_q;
  assign ACK_O             = ack_q;
  assign PPD_ENABLE        = pdn_en_q;
  assign DEEP_STOP_SELECT  = mode_sel_q;
  assign LOW_POWER_REG_EN  = lp_reg_q;
  assign DETECT_THRESH_SEL = det_sel_q;
  assign WARN_THRESH_SEL   = wrn_sel_q;
  assign WARN_IRQ          = irq_q;
  assign PERIPH_CLK_EN     = gate_q;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // Second power register: acknowledge, lock, select and regulator interplay
  chk_flag_ack_clear: assert property (
    (CLK_EN && wr_pm2 && wd[pmcg_pkg::PM2_ACK_BIT] && !DEEP_STOP_WAKE) |=> !pdn_flag_q)
    else $error("flag not cleared by acknowledge");
  chk_flag_ack_zero: assert property (
    (CLK_EN && wr_pm2 && !wd[pmcg_pkg::PM2_ACK_BIT] && !DEEP_STOP_WAKE) |=> $stable(pdn_flag_q))
    else $error("flag changed by a zero acknowledge");
  chk_enable_once: assert property (
    (CLK_EN && wr_pm2 && once_if.locked[0] && !DEEP_STOP_WAKE) |=> $stable(pdn_en_q))
    else $error("write-once enable changed twice");
  chk_lock_set: assert property (
    (CLK_EN && wr_pm2) |=> once_if.locked[0])
    else $error("write-once latch not set by a write");
  chk_select_clear: assert property (
    (CLK_EN && wr_pm2 && !wd[pmcg_pkg::PM2_SEL_BIT] && !DEEP_STOP_WAKE) |=> !mode_sel_q)
    else $error("shallow stop not selected by a zero write");
  chk_select_needs_enable: assert property (
    mode_sel_q |-> pdn_en_q)
    else $error("select set without enable");
  chk_select_lpr_block: assert property (
    (CLK_EN && wr_pm2 && lp_reg_q && !DEEP_STOP_WAKE) |=> !mode_sel_q)
    else $error("select set while regulator bit high");
  chk_both_set: assert property (
    (CLK_EN && wr_pm2 && mode_sel_new && !DEEP_STOP_WAKE) |=> (mode_sel_q && !lp_reg_q))
    else $error("both select and regulator bit set");
  chk_lpreg_write: assert property (
    (CLK_EN && wr_pm2 && !wd[pmcg_pkg::PM2_SEL_BIT] && !DEEP_STOP_WAKE)
      |=> (lp_reg_q == $past(wd[pmcg_pkg::PM2_LPREG_BIT])))
    else $error("regulator bit write lost");
  chk_wake_state: assert property (
    (CLK_EN && DEEP_STOP_WAKE) |=> (pdn_flag_q && pdn_en_q && mode_sel_q && !lp_reg_q))
    else $error("wake from deep stop did not set mode state");

  // Third power register: warning flag, thresholds and interrupt
  chk_warn_sticky: assert property (
    (CLK_EN && warn_lvl) |=> warn_flag_q)
    else $error("warning flag cleared while warning present");
  chk_warn_clear: assert property (
    (CLK_EN && wr_pm3 && wd[pmcg_pkg::PM3_ACK_BIT] && !warn_lvl) |=> !warn_flag_q)
    else $error("warning flag not cleared by acknowledge");
  chk_detect_sel: assert property (
    (CLK_EN && wr_pm3) |=> (DETECT_THRESH_SEL == $past(DAT_I[pmcg_pkg::PM3_DET_BIT])))
    else $error("detect threshold select write lost");
  chk_warn_sel: assert property (
    (CLK_EN && wr_pm3) |=> (WARN_THRESH_SEL == $past(DAT_I[pmcg_pkg::PM3_WRN_BIT])))
    else $error("warning threshold select write lost");
  chk_irq_follows: assert property (
    WARN_IRQ == (warn_flag_q && ie_q))
    else $error("interrupt does not follow flag and enable");

  // Clock gate register and bus handshake
  chk_gate_write: assert property (
    (CLK_EN && wr_gate) |=> (PERIPH_CLK_EN == $past(DAT_I[7:0])))
    else $error("gate register write lost");
  chk_gate_hold: assert property (
    (CLK_EN && !wr_gate) |=> $stable(PERIPH_CLK_EN))
    else $error("gate register changed without a write");
  // A frozen clock enable legally holds ack, so only a running cycle counts
  chk_ack_pulse: assert property (
    (ACK_O && CLK_EN) |=> !ACK_O)
    else $error("ack held longer than one cycle");

  // Main scenarios
  cov_deep_select: cover property (CLK_EN && wr_pm2 ##1 mode_sel_q);
  cov_wake_flag:   cover property (DEEP_STOP_WAKE ##1 pdn_flag_q);
  cov_warn_irq:    cover property (warn_lvl && ie_q ##1 WARN_IRQ);
  cov_lock_write:  cover property (CLK_EN && wr_pm2 && once_if.locked[0]);
  cov_warn_clear:  cover property (warn_flag_q && wr_pm3 ##1 !warn_flag_q);
endmodule // pmcg_regs

// file: design/pmcg_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for an analog status
// Assumes: Input is asynchronous to CLOCK
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/10ps
module pmcg_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic [pmcg_pkg::SYNC_STAGES-1:0] sh_q;
  logic [pmcg_pkg::SYNC_STAGES-1:0] sh_d;
  logic                             out_q;
  logic                             out_d;

  // First stage feeds only the second stage
  always_comb begin
    sh_d  = {sh_q[pmcg_pkg::SYNC_STAGES-2:0], din};
    out_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : out_q;
  end

  // Registers frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q  <= '0;
      out_q <= 1'b0;
    end else if (ce) begin
      sh_q  <= sh_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule // pmcg_sync

// file: testbench/pmcg_regs_tb_top.sv
// Purpose: Self-checking bench for the power mode and clock gate register bank
// Assumes: Classic Wishbone master, ack awaited at the rising edge
// Notes:   CLK_EN is held high; the freeze path is not exercised
`timescale 1ns/10ps
module power_mode_and_clock_gating_regs_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        wake = 1'b0;
  logic        warn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        pdn_en, dsel, lp_reg, dth, wth, irq;
  logic [7:0]  gate;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  pmcg_regs u_pmcg_regs (
    .CLOCK(clk), .RESET(rst), .CLK_EN(1'b1), .RESET_IS_POR(por),
    .DEEP_STOP_WAKE(wake), .WARN_BELOW_ASYNC(warn), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .PPD_ENABLE(pdn_en), .DEEP_STOP_SELECT(dsel), .LOW_POWER_REG_EN(lp_reg),
    .DETECT_THRESH_SEL(dth), .WARN_THRESH_SEL(wth), .WARN_IRQ(irq),
    .PERIPH_CLK_EN(gate)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; ack and read data are taken at the rising edge, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    check(what, q, {24'h00_0000, exp});
  endtask

  // Reset lasts eight cycles; p marks a power-on reset
  task automatic do_reset(input logic p);
    @(posedge clk);
    rst <= 1'b1; por <= p;
    repeat (8) @(posedge clk);
    rst <= 1'b0; por <= 1'b0;
  endtask

  initial begin
    do_reset(1'b1);
    rd_chk("pm2_rst", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h00);
    rd_chk("pm3_rst", pmcg_pkg::PMCG_ADR_PM_THREE, 8'h00);
    rd_chk("gate_rst", pmcg_pkg::PMCG_ADR_GATE_ONE, pmcg_pkg::GATE_ONE_RESET);
    rd_chk("unmapped", 4'hC, 8'h00);
    $display("test reset done");
    // Alternating patterns move every gate bit; only bits 0, 2, 5 and 7 go both ways
    wr(pmcg_pkg::PMCG_ADR_GATE_ONE, 8'h5A);
    check("gate_port", {24'h0, gate}, 32'h0000_005A);
    wr(pmcg_pkg::PMCG_ADR_GATE_ONE, 8'hA5, 4'h0);
    rd_chk("gate_nosel", pmcg_pkg::PMCG_ADR_GATE_ONE, 8'h5A);
    wr(pmcg_pkg::PMCG_ADR_GATE_ONE, 8'hA5);
    check("gate_port2", {24'h0, gate}, 32'h0000_00A5);
    $display("test gate done");
    // Select refused without enable, then enable locked by the first write
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h01);
    rd_chk("pm2_noen", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h00);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h03);
    rd_chk("pm2_lock", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h00);
    check("enable_port", {31'h0, pdn_en}, 32'h0000_0000);
    do_reset(1'b0);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h83);
    rd_chk("pm2_both", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h03);
    check("deep_sel", {31'h0, dsel}, 32'h0000_0001);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h02);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h80);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h81);
    rd_chk("pm2_regbit", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h82);
    check("regbit_port", {31'h0, lp_reg}, 32'h0000_0001);
    $display("test mode done");
    // Wake from deep stop, then acknowledge with 0 and with 1
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    rd_chk("pm2_wake", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h0B);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h03);
    rd_chk("pm2_ack0", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h0B);
    wr(pmcg_pkg::PMCG_ADR_PM_TWO, 8'h07);
    rd_chk("pm2_ack1", pmcg_pkg::PMCG_ADR_PM_TWO, 8'h03);
    $display("test wake done");
    // Warning flag is sticky and cannot be cleared while the supply is still low
    wr(pmcg_pkg::PMCG_ADR_PM_THREE, 8'h38);
    check("thresh", {30'h0, dth, wth}, 32'h0000_0003);
    warn <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk("warn_set", pmcg_pkg::PMCG_ADR_PM_THREE, 8'hB8);
    check("irq_on", {31'h0, irq}, 32'h0000_0001);
    wr(pmcg_pkg::PMCG_ADR_PM_THREE, 8'h78);
    rd_chk("warn_held", pmcg_pkg::PMCG_ADR_PM_THREE, 8'hB8);
    warn <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk("warn_sticky", pmcg_pkg::PMCG_ADR_PM_THREE, 8'hB8);
    wr(pmcg_pkg::PMCG_ADR_PM_THREE, 8'h78);
    rd_chk("warn_clr", pmcg_pkg::PMCG_ADR_PM_THREE, 8'h38);
    check("irq_off", {31'h0, irq}, 32'h0000_0000);
    warn <= 1'b1;
    repeat (8) @(posedge clk);
    wr(pmcg_pkg::PMCG_ADR_PM_THREE, 8'h30);
    check("irq_masked", {31'h0, irq}, 32'h0000_0000);
    $display("test warning done");
    // Supply already low at reset end; a non power-on reset keeps the selects
    do_reset(1'b0);
    repeat (8) @(posedge clk);
    rd_chk("pm3_lvr", pmcg_pkg::PMCG_ADR_PM_THREE, 8'hB0);
    warn <= 1'b0;
    do_reset(1'b1);
    rd_chk("pm3_por", pmcg_pkg::PMCG_ADR_PM_THREE, 8'h00);
    $display("test reset kinds done");
    report_and_stop();
  end
endmodule // power_mode_and_clock_gating_regs_tb_top
